// file: src/slb_controller.sv
// self-test controller: register slave, remote setup, per-port pattern checkers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// per-port pattern checker
// ----------------------------------------
module slb_port_check (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic active_in,
    input wire logic clear_in,
    input wire logic stop_in,
    input wire logic lock_in,
    input wire logic bit_valid_in,
    input wire logic bit_in,
    output logic [7:0] tally_out,
    output logic err_out
);
    import slb_pkg::*;
    logic [6:0] sr;
    logic [2:0] fill;
    logic seen;
    logic lost;
    // self-synchronising prbs7: expected bit comes from the last received ones
    wire expect_bit = sr[6] ^ sr[5];
    wire synced = (fill == PRBS_FILL);
    wire mism = active_in & lock_in & bit_valid_in & synced & (bit_in != expect_bit); // [RULE4] [RULE3]
    wire lost_now = lost | (active_in & seen & ~lock_in);
    wire fail = lost_now | (stop_in & ~seen);
    wire [7:0] next_tally = fail ? TALLY_FAIL :
        (mism && tally_out < TALLY_MAX) ? 8'(tally_out + 8'h01) : tally_out; // [RULE7] [RULE18]
    wire [2:0] next_fill = ~lock_in ? 3'h0 :
        (bit_valid_in && !synced) ? 3'(fill + 3'h1) : fill;

    always_ff @(posedge clk_in) begin
        if (!nrst_in || clear_in) begin // [RULE18]
            sr <= 7'h00;
            fill <= 3'h0;
            seen <= 1'b0;
            lost <= 1'b0;
            tally_out <= 8'h00;
            err_out <= 1'b0;
        end else begin
            if (bit_valid_in && lock_in) begin
                sr <= {sr[5:0], bit_in};
            end
            fill <= next_fill;
            seen <= seen | (active_in & lock_in);
            lost <= lost_now;
            tally_out <= next_tally;
            err_out <= mism;
        end
    end
endmodule

// ----------------------------------------
// top level
// ----------------------------------------
module slb_controller (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output slb_pkg::slb_bc_t bc_req_out,
    output logic bc_valid_out,
    input wire logic bc_ready_in,
    input wire logic remote_selftest_active_in,
    input wire logic [slb_pkg::NPORT-1:0] rx_lock_in,
    input wire logic [slb_pkg::NPORT-1:0] rx_bit_valid_in,
    input wire logic [slb_pkg::NPORT-1:0] rx_bit_in,
    input wire logic pgen_enable_in,
    output logic [slb_pkg::NPORT-1:0] pass_out,
    output logic [slb_pkg::NGPIO-1:0] gpio_out,
    output logic outputs_enable_out,
    output logic csi_lp11_out,
    output logic serial_monitor_output_out
);
    import slb_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] selftest_control;
    logic [7:0] page;
    logic [7:0] gpio_pin_config [NGPIO];
    logic [1:0] clk_sel;
    slb_state_t state;
    logic [7:0] tally [NPORT];
    logic [NPORT-1:0] err_vec;

    wire [1:0] sel_port = page[PAGE_LSB+1:PAGE_LSB];
    wire [1:0] selftest_output_gating = selftest_control[GATE_LSB+1:GATE_LSB];
    wire [1:0] selftest_clock_select = selftest_control[CLK_LSB+1:CLK_LSB];
    wire ctrl_en = selftest_control[CTRL_EN_BIT];
    wire wr_ctrl = wr_in & (addr_in == CTRL_OFF);
    wire wr_page = wr_in & (addr_in == PAGE_OFF);
    wire is_gpio = (addr_in[7:2] == GPIO_OFF[7:2]);
    wire [7:0] dbg_val = 8'({remote_selftest_active_in, 5'h00}); // [RULE11]
    wire [7:0] gpio_rd = gpio_pin_config[addr_in[1:0]];
    wire [7:0] next_rdata = !rd_in ? 8'h00 :
        (addr_in == TALLY_OFF) ? tally[sel_port] : // [RULE6]
        (addr_in == CTRL_OFF) ? selftest_control :
        (addr_in == DBG_OFF) ? dbg_val :
        (addr_in == PAGE_OFF) ? page :
        is_gpio ? gpio_rd : 8'h00;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            selftest_control <= CTRL_RST;
            page <= PAGE_RST;
            rdata_out <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                selftest_control <= wdata_in; // [RULE1]
            end
            if (wr_page) begin
                page <= wdata_in;
            end
            rdata_out <= next_rdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NGPIO; g++) begin : gpio_cfg
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    gpio_pin_config[g] <= GPIO_RST;
                end else if (wr_in && is_gpio && addr_in[1:0] == 2'(g)) begin
                    gpio_pin_config[g] <= wdata_in;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // remote setup sequence
    // ----------------------------------------
    // setup waits on the back channel, so checkers only run once the write is taken
    wire bc_take = bc_valid_out & bc_ready_in;
    wire start_p = (state == ST_IDLE) & ctrl_en;
    wire stop_p = (state == ST_RUN) & ~ctrl_en;
    slb_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (ctrl_en) begin
                next_state = ST_SEND_ON; // [RULE1]
            end
            ST_SEND_ON: if (bc_take) begin
                next_state = ST_RUN; // [RULE2]
            end
            ST_RUN: if (!ctrl_en) begin
                next_state = ST_SEND_OFF; // [RULE1]
            end
            ST_SEND_OFF: if (bc_take) begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end
    wire next_on = (next_state == ST_SEND_ON);
    wire next_off = (next_state == ST_SEND_OFF);
    // the first on word leaves at the start edge, before clk_sel has loaded
    wire [1:0] fwd_sel = start_p ? selftest_clock_select : clk_sel;
    wire [7:0] on_val = 8'({fwd_sel, 1'b1}); // [RULE14]
    slb_bc_t next_bc;
    assign next_bc.addr = REMOTE_REG;
    assign next_bc.data = next_on ? on_val : REMOTE_OFF_VAL;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            clk_sel <= 2'h0;
            bc_valid_out <= 1'b0;
            bc_req_out <= '0;
        end else begin
            state <= next_state;
            if (start_p) begin
                clk_sel <= selftest_clock_select; // [RULE15]
            end
            bc_valid_out <= next_on | next_off; // [RULE2]
            bc_req_out <= next_bc;
        end
    end
    // gating covers the stop write too, so outputs stay off until the remote is back
    wire test_on = (state != ST_IDLE);

    // ----------------------------------------
    // port checkers and outputs
    // ----------------------------------------
    generate
        for (g = 0; g < NPORT; g++) begin : port
            slb_port_check u_chk (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .active_in(state == ST_RUN),
                .clear_in(start_p),
                .stop_in(stop_p),
                .lock_in(rx_lock_in[g]),
                .bit_valid_in(rx_bit_valid_in[g]),
                .bit_in(rx_bit_in[g]),
                .tally_out(tally[g]),
                .err_out(err_vec[g])
            );
        end
    endgenerate

    logic [NGPIO-1:0] next_gpio;
    generate
        for (g = 0; g < NGPIO; g++) begin : gpio_sel
            wire [1:0] gsrc = gpio_pin_config[g][1:0];
            wire [1:0] gport = gpio_pin_config[g][GPIO_PORT_LSB+1:GPIO_PORT_LSB];
            assign next_gpio[g] = (gsrc == SRC_PASS) ? ~err_vec[gport] : // [RULE9]
                (gsrc == SRC_LOCK) ? rx_lock_in[gport] : 1'b0;
        end
    endgenerate

    wire gate_on = (selftest_output_gating == GATE_ON);
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pass_out <= '1;
            gpio_out <= '0;
            outputs_enable_out <= 1'b1;
            csi_lp11_out <= 1'b0;
            serial_monitor_output_out <= 1'b0;
        end else begin
            pass_out <= ~err_vec; // [RULE8]
            gpio_out <= next_gpio;
            outputs_enable_out <= ~test_on | gate_on; // [RULE12]
            csi_lp11_out <= test_on & gate_on & ~pgen_enable_in; // [RULE13]
            serial_monitor_output_out <= rx_bit_in[sel_port]; // [RULE17]
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    start_seq_a: assert property ((state == ST_IDLE) && ctrl_en |=> state == ST_SEND_ON) // [RULE1]
        else $error("test start not taken");
    stop_seq_a: assert property ((state == ST_RUN) && !ctrl_en |=> state == ST_SEND_OFF) // [RULE1]
        else $error("test stop not taken");
    remote_write_a: assert property ($rose(state == ST_RUN) |-> $past(bc_take)) // [RULE2]
        else $error("run without remote write");
    clk_fwd_a: assert property (bc_valid_out && state == ST_SEND_ON |-> // [RULE14]
        bc_req_out.data[2:1] == clk_sel && bc_req_out.data[0])
        else $error("clock select not forwarded");
    clk_hold_a: assert property (state != ST_IDLE |=> $stable(clk_sel)) // [RULE15]
        else $error("clock select changed in test");
    tally_clear_a: assert property (state == ST_SEND_ON |-> tally[0] == 8'h00) // [RULE18]
        else $error("tally not cleared at start");
    tally_cap_a: assert property ($past(tally[0]) == TALLY_MAX && !$past(start_p) && // [RULE7]
        tally[0] != TALLY_MAX |-> tally[0] == TALLY_FAIL)
        else $error("tally wrapped past max");
    pass_low_a: assert property (err_vec[0] |=> !pass_out[0]) // [RULE8]
        else $error("pass not low on error");
    gate_off_a: assert property (test_on && selftest_output_gating == GATE_OFF |=> // [RULE12]
        !outputs_enable_out)
        else $error("outputs not gated");
    dbg_read_a: assert property (rd_in && addr_in == DBG_OFF |=> // [RULE11]
        rdata_out[DBG_ACT_BIT] == $past(remote_selftest_active_in))
        else $error("remote active bit wrong");
    tally_read_a: assert property (rd_in && addr_in == TALLY_OFF |=> // [RULE6]
        rdata_out == $past(tally[sel_port]))
        else $error("tally read wrong");
    gate_on_a: assert property (test_on && gate_on |=> outputs_enable_out) // [RULE12]
        else $error("outputs not enabled");
    lp11_on_a: assert property (test_on && gate_on && !pgen_enable_in |=> // [RULE13]
        csi_lp11_out)
        else $error("transmitter not held idle");
    lp11_off_a: assert property (!test_on || pgen_enable_in |=> !csi_lp11_out) // [RULE13]
        else $error("transmitter idle hold stuck");
    mon_copy_a: assert property (1'b1 |=> // [RULE17]
        serial_monitor_output_out == $past(rx_bit_in[sel_port]))
        else $error("monitor output lost");
    tally_hold_a: assert property (state == ST_IDLE && !ctrl_en |=> // [RULE6]
        $stable(tally[0]))
        else $error("tally changed after test");
    bc_hold_a: assert property (bc_valid_out && !bc_ready_in |=> // [RULE2]
        bc_valid_out && $stable(bc_req_out))
        else $error("back-channel write dropped");
    pass_high_a: assert property (!err_vec[0] |=> pass_out[0]) // [RULE8]
        else $error("pass low without error");
    err_run_a: assert property (err_vec[0] |-> $past(state == ST_RUN)) // [RULE4]
        else $error("error outside test");
    fail_keep_a: assert property (tally[0] == TALLY_FAIL && !start_p |=> // [RULE7]
        tally[0] == TALLY_FAIL)
        else $error("fail mark lost");

    run_c: cover property (state == ST_SEND_ON ##[1:20] state == ST_RUN);
    stop_c: cover property (state == ST_SEND_OFF ##[1:20] state == ST_IDLE);
    err_c: cover property (state == ST_RUN && err_vec[0]);
    fail_c: cover property (tally[0] == TALLY_FAIL);
    lp11_c: cover property (state == ST_RUN && csi_lp11_out);
endmodule

`default_nettype wire

// file: src/slb_pkg.sv
// constants and types of the serial link self-test controller
// Function
// [RULE1] 0x01 starts test, zero stops it
// [RULE2] start sends back-channel writes to remote
// [RULE3] remote sends pseudo-random stream at rate
// [RULE4] each port checks every received pattern bit; code skips the first 7 valid bits after start or lock
// [RULE5] remote counts back-channel CRC errors
// [RULE6] per-port error tally readable at 0x57
// [RULE7] no or lost lock reads 0xFF
// [RULE8] pass indication low per data error
// [RULE9] pass indication routable to gpio pins
// [RULE10] route lock status to gpio too
// [RULE11] 0xD0 bit 5 shows remote test active
// [RULE12] bits 7:6 gate outputs, 00 off 10 on
// [RULE13] enabled outputs keep CSI-2 in LP11; code drops LP11 while pgen_enable_in is high
// [RULE14] clock select forwarded to remote 0x14[2:1]
// [RULE15] clock select sampled only at test start
// [RULE16] software avoids clock select value 11
// [RULE17] serial monitor output stays available
// [RULE18] tally cleared at start, saturates
package slb_pkg;
    localparam int NPORT = 4;
    localparam int NGPIO = 4;
    localparam logic [7:0] GPIO_OFF = 8'h10;
    localparam logic [7:0] PAGE_OFF = 8'h4C;
    localparam logic [7:0] TALLY_OFF = 8'h57;
    localparam logic [7:0] CTRL_OFF = 8'hB3;
    localparam logic [7:0] DBG_OFF = 8'hD0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] GPIO_RST = 8'h00;
    localparam int CTRL_EN_BIT = 0;
    localparam int CLK_LSB = 1;
    localparam int GATE_LSB = 6;
    localparam int DBG_ACT_BIT = 5;
    localparam int PAGE_LSB = 4;
    localparam int GPIO_PORT_LSB = 4;
    localparam logic [1:0] GATE_ON = 2'h2;
    localparam logic [1:0] GATE_OFF = 2'h0;
    localparam logic [1:0] SRC_PASS = 2'h1;
    localparam logic [1:0] SRC_LOCK = 2'h2;
    localparam logic [7:0] REMOTE_REG = 8'h14;
    localparam logic [7:0] REMOTE_OFF_VAL = 8'h00;
    localparam logic [7:0] TALLY_MAX = 8'hFE;
    localparam logic [7:0] TALLY_FAIL = 8'hFF;
    localparam logic [2:0] PRBS_FILL = 3'h7;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } slb_bc_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND_ON, ST_RUN, ST_SEND_OFF} slb_state_t;
endpackage

// file: tb/slb_remote_model.sv
// remote serializer model: back-channel slave and test pattern source
`timescale 1ns/1ns
`default_nettype none
module slb_remote_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire slb_pkg::slb_bc_t bc_req_in,
    input wire logic bc_valid_in,
    input wire logic slow_in,
    input wire logic [slb_pkg::NPORT-1:0] inv_in,
    output logic bc_ready_out,
    output logic active_out,
    output logic [1:0] clk_sel_out,
    output logic [slb_pkg::NPORT-1:0] bit_out,
    output logic [slb_pkg::NPORT-1:0] bit_valid_out,
    output logic [7:0] bc_err_out
);
    import slb_pkg::*;
    // ----------------------------------------
    // back channel and pattern
    // ----------------------------------------
    logic [6:0] lfsr;
    logic tog;
    // no crc rides this carrier: a foreign register or stray data bits mark a damaged frame
    wire frame_bad = (bc_req_in.addr != REMOTE_REG) || (bc_req_in.data[7:3] != 5'h00);
    // slow mode accepts only every other cycle
    assign bc_ready_out = slow_in ? tog : 1'b1;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            tog <= 1'b0;
            active_out <= 1'b0;
            clk_sel_out <= 2'h0;
            lfsr <= 7'h7F;
            bit_out <= '0;
            bit_valid_out <= '0;
            bc_err_out <= 8'h00;
        end else begin
            tog <= ~tog;
            if (bc_valid_in && bc_ready_out && bc_req_in.addr == REMOTE_REG) begin
                active_out <= bc_req_in.data[0];
                clk_sel_out <= bc_req_in.data[2:1];
            end
            if (bc_valid_in && bc_ready_out && frame_bad) begin
                bc_err_out <= 8'(bc_err_out + 8'h01);
            end
            lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
            bit_valid_out <= {NPORT{active_out}};
            // idle line toggles so a stale bit never passes for data
            bit_out <= active_out ? ({NPORT{lfsr[6] ^ lfsr[5]}} ^ inv_in) : ~bit_out;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_slb_controller.sv
// self-checking bench of the serial link self-test controller
`timescale 1ns/1ns
`default_nettype none
module tb_slb_controller;
    import slb_pkg::*;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    logic clk_in, nrst_in, wr, rd, oe, lp11, mon, act, slow, pgen, bvalid, bready, b;
    logic [7:0] addr, wdata, rdata, v, berr;
    logic [NPORT-1:0] lock, rbit, rval, inv, pass;
    logic [NGPIO-1:0] gpio;
    logic [1:0] csel;
    slb_bc_t req;
    int miscompares, comparisons, lows;
    slb_controller slb_controller_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .bc_req_out(req), .bc_valid_out(bvalid), .bc_ready_in(bready),
        .remote_selftest_active_in(act), .rx_lock_in(lock), .rx_bit_valid_in(rval),
        .rx_bit_in(rbit), .pgen_enable_in(pgen), .pass_out(pass), .gpio_out(gpio),
        .outputs_enable_out(oe), .csi_lp11_out(lp11), .serial_monitor_output_out(mon));
    slb_remote_model slb_remote_model_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .bc_req_in(req), .bc_valid_in(bvalid), .slow_in(slow), .inv_in(inv),
        .bc_ready_out(bready), .active_out(act), .clk_sel_out(csel),
        .bit_out(rbit), .bit_valid_out(rval), .bc_err_out(berr));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (pass[1] === 1'b0) lows++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic tally(input logic [1:0] p, input logic [7:0] e);
        wr_reg(PAGE_OFF, {2'h0, p, 4'h0});
        rd_reg(TALLY_OFF);
        chk(v, e);
    endtask
    // bounded wait: a lost back-channel write must not hang the run
    task automatic wait_act(input logic e);
        for (int i = 0; i < 40 && act !== e; i++) @(posedge clk_in);
        chk({7'h0, act}, {7'h0, e});
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end
    initial begin
        nrst_in = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        lock = 4'hB;
        inv = 4'h0;
        slow = 1'b0;
        pgen = 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_reg(CTRL_OFF);
        chk(v, CTRL_RST);
        rd_reg(8'h20);
        chk(v, 8'h00);
        wr_reg(8'h10, 8'h22);
        wr_reg(CTRL_OFF, 8'h03);
        wait_act(1'b1);
        chk({6'h0, csel}, 8'h01);
        rd_reg(DBG_OFF);
        chk(v, 8'h20);
        chk({7'h0, oe}, 8'h00);
        chk({7'h0, gpio[0]}, 8'h00);
        wr_reg(CTRL_OFF, 8'h05);
        repeat (20) @(posedge clk_in);
        chk({6'h0, csel}, 8'h01);
        @(posedge clk_in);
        b = rbit[0];
        #1 chk({7'h0, mon}, {7'h0, b});
        lows = 0;
        @(posedge clk_in);
        inv <= 4'h2;
        @(posedge clk_in);
        inv <= 4'h0;
        repeat (20) @(posedge clk_in);
        chk(lows[7:0], 8'h03);
        lock <= 4'h3;
        repeat (4) @(posedge clk_in);
        wr_reg(CTRL_OFF, 8'h00);
        wait_act(1'b0);
        wr_reg(DBG_OFF, 8'hFF);
        rd_reg(DBG_OFF);
        chk(v, 8'h00);
        tally(2'h0, 8'h00);
        tally(2'h1, 8'h03);
        tally(2'h2, TALLY_FAIL);
        tally(2'h3, TALLY_FAIL);
        @(posedge clk_in);
        lock <= 4'hF;
        slow <= 1'b1;
        wr_reg(CTRL_OFF, 8'h85);
        wait_act(1'b1);
        chk({6'h0, csel}, 8'h02);
        chk({7'h0, oe}, 8'h01);
        chk({7'h0, lp11}, 8'h01);
        tally(2'h1, 8'h00);
        @(posedge clk_in);
        inv <= 4'h1;
        repeat (300) @(posedge clk_in);
        inv <= 4'h0;
        pgen <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1 chk({7'h0, lp11}, 8'h00);
        chk({7'h0, gpio[0]}, 8'h01);
        tally(2'h0, TALLY_MAX);
        @(posedge clk_in);
        lock <= 4'hE;
        repeat (3) @(posedge clk_in);
        tally(2'h0, TALLY_FAIL);
        wr_reg(CTRL_OFF, 8'h00);
        wait_act(1'b0);
        chk(berr, 8'h00);
        give_verdict;
    end
endmodule
`default_nettype wire
